// [gic_pkg.sv]
// Package of constants and types for the gate-input acquisition controller
package gic_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ             = 125_000_000;
  localparam int unsigned SYNC_PERIOD_MS     = 100;
  localparam int unsigned SYNC_CYCLES        = CLK_HZ / 1000 * SYNC_PERIOD_MS;
  localparam int unsigned SYNC_PULSE_US      = 1;
  localparam int unsigned SYNC_PULSE_CYCLES  = CLK_HZ / 1_000_000 * SYNC_PULSE_US;
  localparam int unsigned ADDR_WINDOW_S      = 10;
  localparam int unsigned ADDR_WINDOW_CYCLES = CLK_HZ * ADDR_WINDOW_S;
  localparam int unsigned ADDR_RETRY_MS      = 1000;
  localparam int unsigned ADDR_RETRY_CYCLES  = CLK_HZ / 1000 * ADDR_RETRY_MS;

  // Fallback network address 169.254.0.127
  localparam logic [31:0] STATIC_IP = 32'hA9FE007F;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_MODE      = 8'h04;
  localparam logic [7:0] OFS_STATUS    = 8'h08;
  localparam logic [7:0] OFS_EVT_COUNT = 8'h0C;
  localparam logic [7:0] OFS_MON_INDEX = 8'h10;
  localparam logic [7:0] OFS_MON_VALUE = 8'h14;
  localparam logic [7:0] OFS_HOST      = 8'h18;
  localparam logic [7:0] OFS_VIEW      = 8'h1C;
  localparam logic [7:0] OFS_IP_ADDR   = 8'h20;

  // Field positions
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_STOP_BIT  = 1;
  localparam int unsigned CTRL_CLEAR_BIT = 2;
  localparam int unsigned MODE_LIST_BIT  = 3;
  localparam int unsigned HOST_NEW_BIT   = 8;
  localparam int unsigned VIEW_ALT_BIT   = 0;

  // Gate modes
  localparam logic [2:0] MODE_NONE        = 3'h0;
  localparam logic [2:0] MODE_ACQ_CTL     = 3'h1;
  localparam logic [2:0] MODE_ACQ_TRIG    = 3'h2;
  localparam logic [2:0] MODE_COINC       = 3'h3;
  localparam logic [2:0] MODE_EVT_CNT     = 3'h4;
  localparam logic [2:0] MODE_ROUTE       = 3'h5;
  localparam logic [2:0] MODE_SYNC        = 3'h6;
  localparam logic [2:0] MODE_SYNC_MASTER = 3'h7;

  // Reset values and sizes
  localparam logic [2:0] MODE_RST      = MODE_NONE;
  localparam int unsigned NUM_HOSTS    = 4;
  localparam logic [7:0] MON_IDX_EVENT = 8'h00;

  typedef enum logic [2:0] {
    RUN_IDLE  = 3'b001,
    RUN_ARMED = 3'b010,
    RUN_ACQ   = 3'b100
  } gic_run_type;

  typedef enum logic [3:0] {
    ADR_WAIT   = 4'b0001,
    ADR_REQ    = 4'b0010,
    ADR_BOUND  = 4'b0100,
    ADR_STATIC = 4'b1000
  } gic_addr_type;

endpackage

// [gic_pin_sync.sv]
// Three-stage pin synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ns
`default_nettype none
module gic_pin_sync (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic pin_in,
  output var  logic level,
  output var  logic rise
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A change counts only once the last two stages agree
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      level <= 1'b0;
      rise  <= 1'b0;
    end else begin
      rise <= (s2 == s3) && s3 && !level;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule
`default_nettype wire

// [gic_top.sv]
// Gate-input acquisition controller with APB register slave
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module gic_top
  import gic_pkg::*;
#(
  parameter int unsigned SYNC_CNT   = SYNC_CYCLES,
  parameter int unsigned WINDOW_CNT = ADDR_WINDOW_CYCLES,
  parameter int unsigned RETRY_CNT  = ADDR_RETRY_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        gate_in,
  input  wire logic        link_in,
  input  wire logic        pulse_valid,
  input  wire logic        addr_ack,
  input  wire logic [31:0] assigned_ip,
  output var  logic        gate_out,
  output var  logic        store_strobe,
  output var  logic        store_alt,
  output var  logic        time_enable,
  output var  logic        sync_record,
  output var  logic [31:0] sync_stamp,
  output var  logic        view_alt,
  output var  logic        addr_request,
  output var  logic        use_static_addr,
  output var  logic [31:0] ip_addr
);
  function automatic logic reg_known(input logic [7:0] a);
    reg_known = (a == OFS_CTRL) || (a == OFS_MODE) || (a == OFS_STATUS) ||
                (a == OFS_EVT_COUNT) || (a == OFS_MON_INDEX) ||
                (a == OFS_MON_VALUE) || (a == OFS_HOST) || (a == OFS_VIEW) ||
                (a == OFS_IP_ADDR);
  endfunction
  logic                 gate_lvl;
  logic                 gate_rise;
  logic                 link_lvl;
  logic                 wr;
  logic                 start_cmd;
  logic                 stop_cmd;
  logic                 clear_cmd;
  logic [2:0]           mode;
  logic                 list_mode;
  gic_run_type          run_state;
  gic_addr_type         addr_state;
  logic [31:0]          event_count;
  logic [7:0]           mon_index;
  logic [1:0]           host_id;
  logic [NUM_HOSTS-1:0] view_mem;
  logic [31:0]          stamp;
  logic [31:0]          sync_cnt;
  logic                 sync_tick;
  logic                 sync_edge;
  logic [31:0]          win_cnt;
  logic [31:0]          retry_cnt;
  logic                 time_run;
  logic                 store_ok;
  logic [31:0]          next_rdata;
  gic_pin_sync gate_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pin_in  (gate_in),
    .level   (gate_lvl),
    .rise    (gate_rise)
  );
  gic_pin_sync link_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pin_in  (link_in),
    .level   (link_lvl),
    .rise    ()
  );
  // APB slave: one wait state, writes land on the completing edge
  assign wr        = psel && penable && pready && pwrite;
  assign start_cmd = wr && (paddr == OFS_CTRL) && pwdata[CTRL_START_BIT];
  assign stop_cmd  = wr && (paddr == OFS_CTRL) && pwdata[CTRL_STOP_BIT];
  assign clear_cmd = wr && (paddr == OFS_CTRL) && pwdata[CTRL_CLEAR_BIT];
  always_comb begin
    next_rdata = 32'h0;
    if (paddr == OFS_CTRL) begin
      next_rdata = {29'h0, run_state};
    end else if (paddr == OFS_MODE) begin
      next_rdata = {28'h0, list_mode, mode};
    end else if (paddr == OFS_STATUS) begin
      next_rdata = {23'h0, link_lvl, addr_state, gate_lvl, run_state};
    end else if (paddr == OFS_EVT_COUNT) begin
      next_rdata = event_count;
    end else if (paddr == OFS_MON_INDEX) begin
      next_rdata = {24'h0, mon_index};
    end else if (paddr == OFS_MON_VALUE) begin
      next_rdata = (mon_index == MON_IDX_EVENT) ? event_count : 32'h0;
    end else if (paddr == OFS_HOST) begin
      next_rdata = {30'h0, host_id};
    end else if (paddr == OFS_VIEW) begin
      next_rdata = {31'h0, view_mem[host_id]};
    end else if (paddr == OFS_IP_ADDR) begin
      next_rdata = ip_addr;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !reg_known(paddr);
      if (psel && penable && !pready && !pwrite) begin
        prdata <= next_rdata;
      end
    end
  end
  // Mode is locked while a run is in progress so gating never flips mid-spectrum
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode      <= MODE_RST;
      list_mode <= 1'b0;
    end else if (wr && (paddr == OFS_MODE) && (run_state == RUN_IDLE)) begin
      mode      <= pwdata[2:0];
      list_mode <= pwdata[MODE_LIST_BIT];
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      run_state <= RUN_IDLE;
    end else begin
      case (run_state)
        RUN_IDLE: begin
          if (start_cmd) begin
            run_state <= (mode == MODE_ACQ_TRIG) ? RUN_ARMED : RUN_ACQ;
          end
        end
        RUN_ARMED: begin
          if (stop_cmd) begin
            run_state <= RUN_IDLE;
          end else if (gate_rise) begin
            run_state <= RUN_ACQ;
          end
        end
        RUN_ACQ: begin
          if (stop_cmd) begin
            run_state <= RUN_IDLE;
          end
        end
        default: begin
          run_state <= RUN_IDLE;
        end
      endcase
    end
  end
  // Timers stop with the gate only in acquisition-control mode
  assign time_run = (run_state == RUN_ACQ) && ((mode != MODE_ACQ_CTL) || gate_lvl);
  assign store_ok = time_run && ((mode != MODE_COINC) || gate_lvl);
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      time_enable  <= 1'b0;
      store_strobe <= 1'b0;
      store_alt    <= 1'b0;
    end else begin
      time_enable  <= time_run;
      store_strobe <= pulse_valid && store_ok;
      store_alt    <= pulse_valid && store_ok && (mode == MODE_ROUTE) && gate_lvl;
    end
  end
  // A rise in the clearing cycle is kept as the first count
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      event_count <= 32'h0;
    end else if (clear_cmd) begin
      event_count <= {31'h0, (mode == MODE_EVT_CNT) && gate_rise};
    end else if ((mode == MODE_EVT_CNT) && gate_rise) begin
      event_count <= event_count + 32'h1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mon_index <= MON_IDX_EVENT;
    end else if (wr && (paddr == OFS_MON_INDEX)) begin
      mon_index <= pwdata[7:0];
    end
  end
  // Per-connection view select; a newly attached host starts regular
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      host_id  <= 2'h0;
      view_mem <= '0;
    end else if (wr && (paddr == OFS_HOST)) begin
      host_id <= pwdata[1:0];
      if (pwdata[HOST_NEW_BIT]) begin
        view_mem[pwdata[1:0]] <= 1'b0;
      end
    end else if (wr && (paddr == OFS_VIEW)) begin
      view_mem[host_id] <= pwdata[VIEW_ALT_BIT];
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      view_alt <= 1'b0;
    end else begin
      view_alt <= view_mem[host_id];
    end
  end
  // Sync master period; count runs only in master mode
  assign sync_tick = (mode == MODE_SYNC_MASTER) && (sync_cnt == 32'h0);
  always_ff @(posedge ref_clk) begin
    if (reset || (mode != MODE_SYNC_MASTER)) begin
      sync_cnt <= 32'h0;
    end else if (sync_cnt == 32'(SYNC_CNT - 1)) begin
      sync_cnt <= 32'h0;
    end else begin
      sync_cnt <= sync_cnt + 32'h1;
    end
  end
  // Master drives a wide pulse so slave synchronisers cannot miss it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      gate_out <= 1'b0;
    end else if (mode == MODE_SYNC_MASTER) begin
      gate_out <= (sync_cnt < 32'(SYNC_PULSE_CYCLES));
    end else begin
      gate_out <= gate_lvl;
    end
  end
  assign sync_edge = ((mode == MODE_SYNC) && gate_rise) || sync_tick;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stamp       <= 32'h0;
      sync_record <= 1'b0;
      sync_stamp  <= 32'h0;
    end else begin
      stamp       <= stamp + 32'h1;
      sync_record <= list_mode && (run_state == RUN_ACQ) && sync_edge;
      if (list_mode && (run_state == RUN_ACQ) && sync_edge) begin
        sync_stamp <= stamp;
      end
    end
  end
  // Address acquisition after each link connect
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      addr_state <= ADR_WAIT;
    end else begin
      case (addr_state)
        ADR_WAIT: begin
          if (link_lvl) begin
            addr_state <= ADR_REQ;
          end
        end
        ADR_REQ: begin
          if (!link_lvl) begin
            addr_state <= ADR_WAIT;
          end else if (addr_ack) begin
            addr_state <= ADR_BOUND;
          end else if (win_cnt == 32'(WINDOW_CNT - 1)) begin
            addr_state <= ADR_STATIC;
          end
        end
        ADR_BOUND, ADR_STATIC: begin
          if (!link_lvl) begin
            addr_state <= ADR_WAIT;
          end
        end
        default: begin
          addr_state <= ADR_WAIT;
        end
      endcase
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset || (addr_state != ADR_REQ)) begin
      win_cnt   <= 32'h0;
      retry_cnt <= 32'h0;
    end else begin
      win_cnt <= win_cnt + 32'h1;
      if (retry_cnt == 32'(RETRY_CNT - 1)) begin
        retry_cnt <= 32'h0;
      end else begin
        retry_cnt <= retry_cnt + 32'h1;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      addr_request    <= 1'b0;
      use_static_addr <= 1'b0;
      ip_addr         <= 32'h0;
    end else begin
      addr_request    <= (addr_state == ADR_REQ) && (retry_cnt == 32'h0) && link_lvl;
      use_static_addr <= (addr_state == ADR_STATIC);
      if (addr_state == ADR_STATIC) begin
        ip_addr <= STATIC_IP;
      end else if ((addr_state == ADR_REQ) && addr_ack) begin
        ip_addr <= assigned_ip;
      end else if (addr_state == ADR_WAIT) begin
        ip_addr <= 32'h0;
      end
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  sequence armed_no_rise;
    (run_state == RUN_ARMED) && !gate_rise && !stop_cmd;
  endsequence
  sequence evt_rise;
    (mode == MODE_EVT_CNT) && gate_rise && !clear_cmd;
  endsequence
  none_store_a: assert property ((mode == MODE_NONE) && (run_state == RUN_ACQ) && pulse_valid
    |=> store_strobe) else $error("pulse lost in no-gating mode");
  ctl_gate_a: assert property ((mode == MODE_ACQ_CTL) && !gate_lvl
    |=> !store_strobe && !time_enable) else $error("acquired with gate low");
  trig_wait_a: assert property (armed_no_rise |=> run_state == RUN_ARMED)
    else $error("trigger run began without gate edge");
  coinc_time_a: assert property ((mode == MODE_COINC) && (run_state == RUN_ACQ)
    |=> time_enable) else $error("timers stopped in coincidence mode");
  event_count_a: assert property (evt_rise |=> event_count == $past(event_count) + 32'h1)
    else $error("event counter missed an edge");
  route_alt_a: assert property ((mode == MODE_ROUTE) && (run_state == RUN_ACQ) && pulse_valid
    && gate_lvl |=> store_strobe && store_alt) else $error("routing missed alternate");
  view_new_a: assert property (wr && (paddr == OFS_HOST) && pwdata[HOST_NEW_BIT]
    |=> ##1 !view_alt) else $error("new host not on regular view");
  sync_record_a: assert property ((mode == MODE_SYNC) && list_mode && (run_state == RUN_ACQ)
    && gate_rise |=> sync_record) else $error("sync edge not recorded");
  master_pulse_a: assert property (sync_tick |=> gate_out [*8])
    else $error("master pulse not driven");
  bridge_gate_a: assert property ((mode != MODE_SYNC_MASTER) ##1 (mode != MODE_SYNC_MASTER)
    |-> gate_out == $past(gate_lvl)) else $error("gate output not bridged");
  static_ip_a: assert property ((addr_state == ADR_STATIC) |=> ip_addr == STATIC_IP
    && use_static_addr) else $error("fallback address wrong");
  mode_lock_a: assert property ((run_state != RUN_IDLE) |=> mode == $past(mode))
    else $error("mode changed during run");

endmodule
`default_nettype wire

// [gic_net_model.sv]
// Network-side model: address server that answers broadcasts after a set delay
`timescale 1ns/1ns
`default_nettype none
module gic_net_model #(
  parameter int unsigned DELAY    = 20,
  parameter logic [31:0] LEASE_IP = 32'h0A000105
) (
  input  wire logic        ref_clk,
  input  wire logic        answer_en,
  input  wire logic        addr_request,
  output var  logic        addr_ack,
  output var  logic [31:0] assigned_ip
);
  int unsigned wait_cnt;

  initial begin
    wait_cnt = 0;
    addr_ack = 1'b0;
    assigned_ip = ~LEASE_IP;
  end

  // A silent server lets the request window run out; the address bus is only
  // meaningful with the ack, so it keeps toggling to expose early sampling
  always @(posedge ref_clk) begin
    addr_ack <= 1'b0;
    assigned_ip <= ~assigned_ip;
    if (addr_request === 1'b1 && answer_en) begin
      wait_cnt <= DELAY;
    end else if (wait_cnt > 1) begin
      wait_cnt <= wait_cnt - 1;
    end else if (wait_cnt == 1) begin
      wait_cnt <= 0;
      addr_ack <= 1'b1;
      assigned_ip <= LEASE_IP;
    end
  end
endmodule
`default_nettype wire

// [gate_input_acquisition_control_test.sv]
// Self-checking bench for the gate-input acquisition controller
`timescale 1ns/1ns
`default_nettype none
module gate_input_acquisition_control_test;
  import gic_pkg::*;
  localparam int unsigned SYNC_T  = 200;
  localparam int unsigned WIN_T   = 500;
  localparam int unsigned RETRY_T = 100;
  localparam int unsigned LIMIT   = 20000;
  localparam logic [31:0] LEASE   = 32'h0A000105;
  logic        ref_clk, reset, psel, penable, pwrite, gate_in, link_in, pulse_valid;
  logic        answer_en, pready, pslverr, addr_ack, gate_out, store_strobe, store_alt;
  logic        time_enable, sync_record, view_alt, addr_request, use_static_addr, last_go;
  logic        e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, assigned_ip, sync_stamp, ip_addr, q, last_stamp, stamp_gap;
  int          fail_count, comparisons, cyc, rise_at, period, n_store, n_alt, n_sync;
  int          n_req, s;

  gic_top #(.SYNC_CNT(SYNC_T), .WINDOW_CNT(WIN_T), .RETRY_CNT(RETRY_T)) DUT (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gate_in(gate_in), .link_in(link_in), .pulse_valid(pulse_valid), .addr_ack(addr_ack),
    .assigned_ip(assigned_ip), .gate_out(gate_out), .store_strobe(store_strobe),
    .store_alt(store_alt), .time_enable(time_enable), .sync_record(sync_record),
    .sync_stamp(sync_stamp), .view_alt(view_alt), .addr_request(addr_request),
    .use_static_addr(use_static_addr), .ip_addr(ip_addr));

  gic_net_model #(.DELAY(20), .LEASE_IP(LEASE)) net (
    .ref_clk(ref_clk), .answer_en(answer_en), .addr_request(addr_request),
    .addr_ack(addr_ack), .assigned_ip(assigned_ip));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic report_and_stop;
    if (fail_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Output monitors count one-cycle pulses so no pulse is missed between calls
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (store_strobe === 1'b1) n_store <= n_store + 1;
    if (store_strobe === 1'b1 && store_alt === 1'b1) n_alt <= n_alt + 1;
    if (sync_record === 1'b1) n_sync <= n_sync + 1;
    if (sync_record === 1'b1) begin
      stamp_gap <= sync_stamp - last_stamp;
      last_stamp <= sync_stamp;
    end
    if (addr_request === 1'b1) n_req <= n_req + 1;
    if (gate_out === 1'b1 && last_go !== 1'b1) begin
      period <= cyc - rise_at;
      rise_at <= cyc;
    end
    last_go <= gate_out;
    if (cyc == LIMIT) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t mismatch: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // One transfer: setup, then access held until pready is sampled high
  // A stalled slave is caught only by the global cycle limit
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
    tick(2);
  endtask

  task automatic rchk(input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    check(q, exp);
  endtask

  task automatic setmode(input logic lst, input logic [2:0] m);
    wr(OFS_MODE, {28'h0, lst, m});
  endtask

  task automatic gate(input logic lvl);
    gate_in <= lvl;
    tick(8);
  endtask

  // One detector event; count how many were stored and how many went to the alternate memory
  task automatic store_test(input int exp_store, input int exp_alt);
    int s0;
    int a0;
    s0 = n_store;
    a0 = n_alt;
    @(posedge ref_clk);
    pulse_valid <= 1'b1;
    @(posedge ref_clk);
    pulse_valid <= 1'b0;
    tick(4);
    check(32'(n_store - s0), 32'(exp_store));
    check(32'(n_alt - a0), 32'(exp_alt));
  endtask

  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, gate_in, link_in, pulse_valid, answer_en} = 7'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    tick(10);
    reset <= 1'b0;
    rchk(OFS_CTRL, 32'h1);
    rchk(OFS_MODE, 32'h0);
    rchk(OFS_IP_ADDR, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check(32'(e), 32'h1);
    wr(OFS_CTRL, 32'h1);
    store_test(1, 0);
    gate(1'b1);
    store_test(1, 0);
    check(32'(gate_out), 32'h1);
    setmode(1'b0, MODE_COINC);
    rchk(OFS_MODE, 32'h0);
    wr(OFS_CTRL, 32'h2);
    gate(1'b0);
    check(32'(gate_out), 32'h0);
    setmode(1'b0, MODE_ACQ_CTL);
    wr(OFS_CTRL, 32'h1);
    store_test(0, 0);
    gate(1'b1);
    store_test(1, 0);
    check(32'(gate_out), 32'h1);
    gate(1'b0);
    store_test(0, 0);
    wr(OFS_CTRL, 32'h2);
    setmode(1'b0, MODE_ACQ_TRIG);
    wr(OFS_CTRL, 32'h1);
    rchk(OFS_CTRL, 32'h2);
    store_test(0, 0);
    gate(1'b1);
    rchk(OFS_CTRL, 32'h4);
    gate(1'b0);
    store_test(1, 0);
    wr(OFS_CTRL, 32'h2);
    rchk(OFS_CTRL, 32'h1);
    setmode(1'b0, MODE_COINC);
    wr(OFS_CTRL, 32'h1);
    check(32'(time_enable), 32'h1);
    store_test(0, 0);
    gate(1'b1);
    store_test(1, 0);
    gate(1'b0);
    wr(OFS_CTRL, 32'h2);
    setmode(1'b0, MODE_ROUTE);
    wr(OFS_CTRL, 32'h1);
    store_test(1, 0);
    gate(1'b1);
    store_test(1, 1);
    gate(1'b0);
    wr(OFS_CTRL, 32'h2);
    setmode(1'b0, MODE_EVT_CNT);
    wr(OFS_CTRL, 32'h4);
    repeat (3) begin
      gate(1'b1);
      gate(1'b0);
    end
    rchk(OFS_EVT_COUNT, 32'h3);
    wr(OFS_MON_INDEX, 32'h0);
    rchk(OFS_MON_VALUE, 32'h3);
    wr(OFS_MON_INDEX, 32'h1);
    rchk(OFS_MON_INDEX, 32'h1);
    rchk(OFS_MON_VALUE, 32'h0);
    wr(OFS_HOST, 32'h0);
    wr(OFS_VIEW, 32'h1);
    check(32'(view_alt), 32'h1);
    wr(OFS_HOST, 32'h101);
    check(32'(view_alt), 32'h0);
    rchk(OFS_HOST, 32'h1);
    wr(OFS_HOST, 32'h0);
    check(32'(view_alt), 32'h1);
    wr(OFS_VIEW, 32'h0);
    check(32'(view_alt), 32'h0);
    // Sync without list mode must stay silent
    setmode(1'b0, MODE_SYNC);
    wr(OFS_CTRL, 32'h1);
    s = n_sync;
    gate(1'b1);
    gate(1'b0);
    check(32'(n_sync - s), 32'h0);
    wr(OFS_CTRL, 32'h2);
    setmode(1'b1, MODE_SYNC);
    wr(OFS_CTRL, 32'h1);
    gate(1'b1);
    gate(1'b0);
    check(32'(n_sync - s), 32'h1);
    wr(OFS_CTRL, 32'h2);
    // A lone unit in its chain, configured as the only master
    setmode(1'b1, MODE_SYNC_MASTER);
    wr(OFS_CTRL, 32'h1);
    s = n_sync;
    tick(3 * SYNC_T + 10);
    check(32'(period), 32'(SYNC_T));
    check(32'(n_sync - s >= 3), 32'h1);
    check(stamp_gap, 32'(SYNC_T));
    wr(OFS_CTRL, 32'h2);
    // Silent server: requests repeat, then the static fallback takes over
    s = n_req;
    link_in <= 1'b1;
    tick(WIN_T + 50);
    check(32'(n_req - s >= 4), 32'h1);
    check(32'(use_static_addr), 32'h1);
    check(ip_addr, 32'hA9FE007F);
    rchk(OFS_IP_ADDR, 32'hA9FE007F);
    rchk(OFS_STATUS, 32'h181);
    s = n_req;
    tick(300);
    check(32'(n_req - s), 32'h0);
    link_in <= 1'b0;
    answer_en <= 1'b1;
    tick(10);
    link_in <= 1'b1;
    tick(80);
    check(ip_addr, LEASE);
    check(32'(use_static_addr), 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
